// *** hdl/serial_if_control_status.v ***
// serial interface register set with a small async / clocked shift engine
// assumes an APB master on pclk and four shared port pins from outside
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "serial_if_map.vh"

module serial_if_control_status #(
  parameter BIT_CYCLES = `BIT_CYCLES_DEF
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  input  wire [3:0]  pin_in,
  output reg  [3:0]  pin_out,
  output reg  [3:0]  pin_oe,
  input  wire [3:0]  gpio_out,
  input  wire [3:0]  gpio_oe,
  output wire [3:0]  gpio_in
);

  // divider reloads, cut to the 16-bit counters on purpose
  localparam integer FULL_INT = BIT_CYCLES - 1;
  localparam integer HALF_INT = BIT_CYCLES / 2 - 1;
  localparam [15:0]  FULL_DIV = FULL_INT[15:0];
  localparam [15:0]  HALF_DIV = HALF_INT[15:0];

  // control and status state
  reg        pin_en;
  reg [1:0]  mode;
  reg        par_en;
  reg        par_odd;
  reg        rx_en;
  reg        tx_en;
  reg        fe_flag;
  reg        pe_flag;
  reg        ov_flag;
  reg [2:0]  mask;
  reg [2:0]  flag;
  reg [7:0]  data;

  // engine state
  reg        tx_busy;
  reg        rx_busy;
  reg        rx_empty;
  reg [3:0]  tx_cnt;
  reg [15:0] tx_div;
  reg [10:0] tx_sh;
  reg [3:0]  rx_cnt;
  reg [15:0] rx_div;
  reg [10:0] rx_sh;
  reg        ck_run;
  reg        ck_tx;
  reg        ck_rx;
  reg [2:0]  ck_cnt;
  reg [15:0] ck_div;
  reg [7:0]  ck_sh;
  reg        sclk_o;
  reg        serial_data_output;
  reg        rx_load;
  reg [7:0]  rx_byte;
  reg        ev_tx;
  reg        ev_rx;
  reg        ev_fe;
  reg        ev_pe;
  reg        ev_ov;

  // pin synchronisers: stage a is read only by stage b
  reg        sin_a;
  reg        sin_b;
  reg        sclk_a;
  reg        sclk_b;
  reg        sin_d;
  reg        sclk_d;

  wire [15:0] idx = paddr[17:2];
  wire        wr = psel & penable & pwrite & (paddr[1:0] == 2'b00);
  wire [3:0]  wd = pwdata[3:0];
  wire        w_pin = wr & (idx == `IDX_PIN_SELECT);
  wire        w_par = wr & (idx == `IDX_PARITY);
  wire        w_ctl = wr & (idx == `IDX_XFER_CTRL);
  wire        w_err = wr & (idx == `IDX_ERR_FLAGS);
  wire        w_lo = wr & (idx == `IDX_DATA_LO);
  wire        w_hi = wr & (idx == `IDX_DATA_HI);
  wire        w_msk = wr & (idx == `IDX_IRQ_MASK);
  wire        w_flg = wr & (idx == `IDX_IRQ_FLAG);

  // decoded mode
  wire        is_async = mode[1];
  wire        mode8 = (mode == `MODE_ASYNC8);
  wire        slave = (mode == `MODE_CLK_SLAVE);
  wire        tx_go = w_ctl & wd[`BIT_TX_TRIG];
  wire        rx_go = w_ctl & wd[`BIT_RX_TRIG];

  // async frame length: start, data, optional parity, stop
  wire [3:0]  n_bits = (mode8 ? 4'd10 : 4'd9) + {3'b000, par_en};
  wire [7:0]  tx_data = mode8 ? data : {1'b0, data[6:0]};
  wire        tx_par = (^tx_data) ^ par_odd;

  // zero-wait slave: answers in the access phase, never errors
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // synchronise the data and clock pins before any logic reads them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_a <= 1'b1;
      sin_b <= 1'b1;
      sclk_a <= 1'b1;
      sclk_b <= 1'b1;
      sin_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      sin_a <= pin_in[0];
      sin_b <= sin_a;
      sclk_a <= pin_in[2];
      sclk_b <= sclk_a;
      sin_d <= sin_b;
      sclk_d <= sclk_b;
    end
  end

  // control registers written by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en <= 1'b0;
      mode <= 2'b00;
      par_en <= 1'b0;
      par_odd <= 1'b0;
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      mask <= 3'b000;
    end else begin
      if (w_pin) begin
        pin_en <= wd[`BIT_PIN_EN];
        mode <= {wd[`BIT_MODE1], wd[`BIT_MODE0]};
      end
      if (w_par) begin
        par_en <= wd[`BIT_PAR_EN];
        par_odd <= wd[`BIT_PAR_ODD];
      end
      if (w_ctl) begin
        rx_en <= wd[`BIT_RX_EN];
        tx_en <= wd[`BIT_TX_EN];
      end
      if (w_msk)
        mask <= wd[2:0];
    end
  end

  // data buffer: no reset, receive completion beats a same-cycle write
  always @(posedge pclk) begin
    if (w_lo)
      data[3:0] <= wd;
    if (w_hi)
      data[7:4] <= wd;
    if (rx_load)
      data <= rx_byte;
  end

  // sticky flags: an event in the clearing cycle wins over the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_flag <= 1'b0;
      pe_flag <= 1'b0;
      ov_flag <= 1'b0;
      flag <= 3'b000;
    end else begin
      fe_flag <= (fe_flag & ~(w_err & wd[`BIT_FRAMING])) | ev_fe;
      pe_flag <= (pe_flag & ~(w_err & wd[`BIT_PARITY])) | ev_pe;
      ov_flag <= (ov_flag & ~(w_err & wd[`BIT_OVERRUN])) | ev_ov;
      flag <= (flag & ~({3{w_flg}} & wd[2:0]))
              | {ev_fe | ev_pe | ev_ov, ev_tx, ev_rx};
    end
  end

  assign irq = |(flag & mask);

  // shift engine: async frames or an 8-bit clocked exchange, lsb first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
      rx_empty <= 1'b1;
      tx_cnt <= 4'd0;
      tx_div <= 16'd0;
      tx_sh <= 11'h7ff;
      rx_cnt <= 4'd0;
      rx_div <= 16'd0;
      rx_sh <= 11'h000;
      ck_run <= 1'b0;
      ck_tx <= 1'b0;
      ck_rx <= 1'b0;
      ck_cnt <= 3'd0;
      ck_div <= 16'd0;
      ck_sh <= 8'h00;
      sclk_o <= 1'b1;
      serial_data_output <= 1'b1;
      rx_load <= 1'b0;
      rx_byte <= 8'h00;
      ev_tx <= 1'b0;
      ev_rx <= 1'b0;
      ev_fe <= 1'b0;
      ev_pe <= 1'b0;
      ev_ov <= 1'b0;
    end else begin
      rx_load <= 1'b0;
      ev_tx <= 1'b0;
      ev_rx <= 1'b0;
      ev_fe <= 1'b0;
      ev_pe <= 1'b0;
      ev_ov <= 1'b0;
      if (is_async) begin
        // buffer declared empty by software
        if (rx_go)
          rx_empty <= 1'b1;
        // transmitter
        if (!tx_busy) begin
          serial_data_output <= 1'b1;
          if (tx_go & tx_en) begin
            tx_busy <= 1'b1;
            tx_cnt <= n_bits;
            tx_div <= FULL_DIV;
            if (par_en)
              tx_sh <= mode8 ? {1'b1, tx_par, tx_data, 1'b0}
                             : {2'b11, tx_par, tx_data[6:0], 1'b0};
            else
              tx_sh <= mode8 ? {2'b11, tx_data, 1'b0}
                             : {3'b111, tx_data[6:0], 1'b0};
          end
        end else if (tx_div != 16'd0) begin
          tx_div <= tx_div - 16'd1;
          serial_data_output <= tx_sh[0];
        end else begin
          tx_div <= FULL_DIV;
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_cnt <= tx_cnt - 4'd1;
          if (tx_cnt == 4'd1) begin
            tx_busy <= 1'b0;
            ev_tx <= 1'b1;
          end
        end
        // receiver: start on a falling data edge, sample mid-bit
        if (!rx_busy) begin
          if (rx_en & sin_d & !sin_b) begin
            rx_busy <= 1'b1;
            rx_cnt <= n_bits;
            rx_div <= HALF_DIV;
          end
        end else if (rx_div != 16'd0) begin
          rx_div <= rx_div - 16'd1;
        end else begin
          rx_div <= FULL_DIV;
          rx_sh[n_bits - rx_cnt] <= sin_b;
          rx_cnt <= rx_cnt - 4'd1;
          if (rx_cnt == 4'd1) begin
            rx_busy <= 1'b0;
            rx_load <= 1'b1;
            rx_empty <= 1'b0;
            rx_byte <= mode8 ? rx_sh[8:1] : {1'b0, rx_sh[7:1]};
            ev_rx <= 1'b1;
            ev_fe <= !sin_b;
            ev_pe <= par_en & ((mode8 ? ^rx_sh[9:1] : ^rx_sh[8:1])
                     ^ par_odd);
            ev_ov <= !rx_empty;
          end
        end
        if (!rx_en)
          rx_busy <= 1'b0;
      end else begin
        // clocked modes: one transfer moves both directions at once
        if (!ck_run) begin
          sclk_o <= 1'b1;
          if ((tx_go & tx_en) | (rx_go & rx_en)) begin
            ck_run <= 1'b1;
            ck_tx <= tx_go & tx_en;
            ck_rx <= rx_go & rx_en;
            tx_busy <= tx_go & tx_en;
            rx_busy <= rx_go & rx_en;
            ck_sh <= data;
            serial_data_output <= data[0];
            ck_cnt <= 3'd0;
            ck_div <= HALF_DIV;
          end
        end else if (slave) begin
          if (sclk_d & !sclk_b)
            serial_data_output <= ck_sh[0];
          else if (!sclk_d & sclk_b) begin
            ck_sh <= {sin_b, ck_sh[7:1]};
            ck_cnt <= ck_cnt + 3'd1;
          end
        end else if (ck_div != 16'd0) begin
          ck_div <= ck_div - 16'd1;
        end else begin
          ck_div <= HALF_DIV;
          sclk_o <= !sclk_o;
          if (sclk_o)
            serial_data_output <= ck_sh[0];
          else begin
            ck_sh <= {sin_b, ck_sh[7:1]};
            ck_cnt <= ck_cnt + 3'd1;
          end
        end
        // the eighth sampling edge ends the transfer
        if (ck_run & (ck_cnt == 3'd7) &
            ((slave & !sclk_d & sclk_b) |
             (!slave & (ck_div == 16'd0) & !sclk_o))) begin
          ck_run <= 1'b0;
          tx_busy <= 1'b0;
          rx_busy <= 1'b0;
          ev_tx <= ck_tx;
          ev_rx <= ck_rx;
          rx_load <= ck_rx;
          rx_byte <= {sin_b, ck_sh[7:1]};
        end
      end
    end
  end

  // register read, captured in the setup phase; unused bits read 0
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & !penable) begin
      prdata <= 32'h0000_0000;
      if (paddr[1:0] == 2'b00) begin
        case (idx)
          `IDX_PIN_SELECT:
            prdata[3:0] <= {1'b0, mode, pin_en};
          `IDX_PARITY:
            prdata[3:0] <= {par_en, par_odd, 2'b00};
          `IDX_XFER_CTRL:
            prdata[3:0] <= {rx_busy, rx_en, tx_busy, tx_en};
          `IDX_ERR_FLAGS:
            prdata[3:0] <= {1'b0, fe_flag, pe_flag, ov_flag};
          `IDX_DATA_LO:
            prdata[3:0] <= data[3:0];
          `IDX_DATA_HI:
            prdata[3:0] <= data[7:4];
          `IDX_IRQ_MASK:
            prdata[3:0] <= {1'b0, mask};
          `IDX_IRQ_FLAG:
            prdata[3:0] <= {1'b0, flag};
          default:
            prdata[3:0] <= 4'h0;
        endcase
      end
    end
  end

  // pin function: serial roles when enabled, port logic otherwise.
  // the clock pin may glitch at the switch; software must wait first
  assign gpio_in = pin_in;
  always @* begin
    pin_out = gpio_out;
    pin_oe = gpio_oe;
    if (pin_en) begin
      pin_out[0] = 1'b0;
      pin_oe[0] = 1'b0;
      pin_out[1] = serial_data_output;
      pin_oe[1] = 1'b1;
      if (!is_async) begin
        pin_out[2] = sclk_o;
        pin_oe[2] = !slave;
      end
      if (slave) begin
        pin_out[3] = !ck_run;
        pin_oe[3] = 1'b1;
      end
    end
  end

endmodule // serial_if_control_status

// *** include/serial_if_map.vh ***
// register map, field positions and timing counts of the serial interface
// assumes APB word addressing: byte address = register index * 4
// Function
// - transfer_control bit 2 is receive_enable, read/write, reset 0.
// - transfer_control bit 0 is transmit_enable, read/write, reset 0.
// - transmit_trigger reads 1 while sending; writing 1 starts sending; reset 0.
// - framing_error_flag reads 1 after framing error; write 1 clears; reset 0.
// - parity_error_flag reads 1 after parity mismatch; write 1 clears; reset 0.
// - overrun_error_flag reads 1 after overrun; write 1 clears; reset 0.
// - eight data bits split low nibble, high nibble; bit 0 is lsb; 1 is high.
// - data bits are not reset; content after reset is undefined.
// - three interrupt mask bits: error, tx done, rx done; 1 enables; reset 0.
// - three interrupt flags set on events; write 1 clears, write 0 ignored.
// - unused register bits always read 0.
// - pin enable 1 maps pins to data in, data out, clock, ready; code maps clock in clocked modes only, ready in slave mode only.
// - pin enable 0 returns pins to general port use; readable, reset 0.
// - async reception completing before buffer declared empty sets overrun.
// - error flag set on parity, framing or overrun error, mask regardless.
// - mode 11 async 8-bit, 10 async 7-bit, 01 clocked slave, 00 master.
`ifndef SERIAL_IF_MAP_VH
`define SERIAL_IF_MAP_VH

// register indices; byte address is index * 4
`define IDX_PIN_SELECT   16'hff70
`define IDX_PARITY       16'hff71
`define IDX_XFER_CTRL    16'hff72
`define IDX_ERR_FLAGS    16'hff73
`define IDX_DATA_LO      16'hff74
`define IDX_DATA_HI      16'hff75
`define IDX_IRQ_MASK     16'hffe3
`define IDX_IRQ_FLAG     16'hfff3

// field positions
`define BIT_PIN_EN       0
`define BIT_MODE0        1
`define BIT_MODE1        2
`define BIT_PAR_ODD      2
`define BIT_PAR_EN       3
`define BIT_TX_EN        0
`define BIT_TX_TRIG      1
`define BIT_RX_EN        2
`define BIT_RX_TRIG      3
`define BIT_OVERRUN      0
`define BIT_PARITY       1
`define BIT_FRAMING      2
`define BIT_IRQ_RX       0
`define BIT_IRQ_TX       1
`define BIT_IRQ_ERR      2

// transfer modes
`define MODE_CLK_MASTER  2'b00
`define MODE_CLK_SLAVE   2'b01
`define MODE_ASYNC7      2'b10
`define MODE_ASYNC8      2'b11

// reset values
`define RST_NIBBLE       4'h0

// default bit period in pclk cycles
`define BIT_CYCLES_DEF   64

// settle time after pin enable, kept by software
`define SETTLE_NS        10000
`define CLK_NS           10
`define SETTLE_CYCLES    ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** tb/serial_if_checker.sv ***
// concurrent checks on the serial interface register block ports
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module serial_if_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        irq,
  input wire [3:0]  pin_out,
  input wire [3:0]  pin_oe,
  input wire [3:0]  gpio_out,
  input wire [3:0]  gpio_oe
);
  localparam [17:0] A_SEL = 18'h3fdc0;
  localparam [17:0] A_CTL = 18'h3fdc8;
  localparam [17:0] A_MSK = 18'h3ff8c;
  reg  [2:0] sel_copy;
  reg  [1:0] en_copy;
  reg  [2:0] msk_copy;
  wire       wr = psel && penable && pwrite;

  // shadows of software-owned bits; flags are event driven, so not kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_copy <= 3'h0;
      en_copy  <= 2'h0;
      msk_copy <= 3'h0;
    end else if (wr) begin
      if (paddr == A_SEL) sel_copy <= pwdata[2:0];
      if (paddr == A_CTL) en_copy <= {pwdata[2], pwdata[0]};
      if (paddr == A_MSK) msk_copy <= pwdata[2:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup(logic [17:0] a);
    psel && !penable && paddr == a;
  endsequence

  property p_gpio;
    !sel_copy[0] |-> pin_out == gpio_out && pin_oe == gpio_oe;
  endproperty
  a_gpio: assert property (p_gpio)
    else $error("port pins not handed to port logic");
  property p_async_pins;
    sel_copy[0] && sel_copy[2] |->
      pin_oe[1:0] == 2'b10 && pin_oe[3:2] == gpio_oe[3:2];
  endproperty
  a_async_pins: assert property (p_async_pins)
    else $error("async pin roles wrong");
  property p_mask_irq;
    msk_copy == 3'h0 |-> !irq;
  endproperty
  a_mask_irq: assert property (p_mask_irq)
    else $error("irq raised with all masks clear");
  property p_ctl_rd;
    s_setup(A_CTL) |=> prdata[2] == en_copy[1] && prdata[0] == en_copy[0];
  endproperty
  a_ctl_rd: assert property (p_ctl_rd)
    else $error("enable bits read back wrong");
  property p_msk_rd;
    s_setup(A_MSK) |=> prdata[3:0] == {1'b0, msk_copy};
  endproperty
  a_msk_rd: assert property (p_msk_rd)
    else $error("mask read back wrong");
  property p_sel_rd;
    s_setup(A_SEL) |=> prdata[3:0] == {1'b0, sel_copy};
  endproperty
  a_sel_rd: assert property (p_sel_rd)
    else $error("pin select read back wrong");
  property p_hi_zero;
    prdata[31:4] == 28'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("unused read bits not zero");
  property p_unaligned;
    psel && !penable && paddr[1:0] != 2'b00 |=> prdata == 32'h0;
  endproperty
  a_unaligned: assert property (p_unaligned)
    else $error("unaligned read not zero");
endmodule // serial_if_checker

// *** tb/serial_partner.sv ***
// far-end serial device: async frames on demand, or a clocked byte exchange
// assumes the line idles high, a bit lasts BIT pclk cycles, link clock 125 ns
`timescale 1ns/1ps
module serial_partner #(
  parameter BIT = 8
) (
  input  wire       pclk,
  input  wire       go,
  input  wire       clocked,
  input  wire [7:0] tx_byte,
  input  wire [1:0] tail,
  input  wire       stop,
  input  wire       line_in,
  input  wire       sclk,
  input  wire       ready,
  output reg        line_out,
  output reg        ck_line,
  output reg        sclk_out,
  output reg  [7:0] got,
  output reg        got_stop,
  output reg  [7:0] ck_got
);
  integer   i;
  integer   j;
  integer   k;
  reg [9:0] frame;
  reg [7:0] ck_sh;

  initial begin
    line_out = 1'b1;
    ck_line = 1'b1;
    sclk_out = 1'b1;
  end

  // async: start bit, data lsb first, optional parity slot, stop, idle;
  // clocked: only load the reply byte, the link clock shifts it out
  always @(posedge go) begin
    if (clocked)
      ck_sh = tx_byte;
    else begin
      frame = tail[1] ? {stop, tail[0], tx_byte} : {1'b1, stop, tx_byte};
      line_out <= 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
        repeat (BIT) @(posedge pclk);
        line_out <= frame[i];
      end
      repeat (BIT) @(posedge pclk);
      line_out <= 1'b1;
    end
  end

  // slave link clock: eight 125 ns periods once ready goes low, else high
  always @(negedge ready) begin
    if (clocked) begin
      for (k = 0; k < 8; k = k + 1) begin
        #62.5 sclk_out = 1'b0;
        #62.5 sclk_out = 1'b1;
      end
    end
  end

  // clocked exchange: next reply bit on the fall, capture on the rise
  always @(negedge sclk) begin
    if (clocked) begin
      ck_line <= ck_sh[0];
      ck_sh = {1'b1, ck_sh[7:1]};
    end
  end
  always @(posedge sclk) begin
    if (clocked)
      ck_got = {line_in, ck_got[7:1]};
  end

  // sample mid bit; a new start edge is only seen once this frame is done
  always @(negedge line_in) begin
    repeat (BIT + BIT / 2) @(posedge pclk);
    for (j = 0; j < 8; j = j + 1) begin
      got[j] = line_in;
      repeat (BIT) @(posedge pclk);
    end
    got_stop = line_in;
  end
endmodule // serial_partner

// *** tb/tb.sv ***
// self-checking bench: apb register tests, async link traffic and clocked master and slave exchanges
// assumes the design map header is on the include path
`timescale 1ns/1ps
`include "serial_if_map.vh"
module tb;
  reg         pclk, presetn, psel, penable, pwrite, go, stop, clocked;
  wire        link_clk, ck_line;
  wire [7:0]  ck_got;
  reg  [17:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [7:0]  tx_byte;
  reg  [1:0]  tail;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, line, got_stop;
  wire [3:0]  pin_out, pin_oe, gpio_in;
  wire [7:0]  got;
  integer     errors, checks, m;

  serial_if_control_status #(.BIT_CYCLES(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .pin_in({1'b1, link_clk, 1'b1, clocked ? ck_line : line}),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .gpio_out(4'ha), .gpio_oe(4'h3), .gpio_in(gpio_in));

  // released data out and ready pins float high through pull-ups; a released clock pin carries the far-end link clock
  serial_partner #(.BIT(8)) u_far (
    .pclk(pclk), .go(go), .clocked(clocked), .tx_byte(tx_byte),
    .tail(tail), .stop(stop),
    .line_in(pin_oe[1] ? pin_out[1] : 1'b1),
    .sclk(pin_oe[2] ? pin_out[2] : link_clk),
    .ready(pin_oe[3] ? pin_out[3] : 1'b1),
    .line_out(line), .ck_line(ck_line), .sclk_out(link_clk),
    .got(got), .got_stop(got_stop), .ck_got(ck_got));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_sim;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task apb(input [15:0] idx, input [1:0] lo, input w, input [3:0] d,
           output [31:0] q);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, lo};
      pwdata <= {28'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [15:0] idx, input [3:0] d);
    apb(idx, 2'b00, 1'b1, d, rd);
  endtask

  task rdc(input [15:0] idx, input [3:0] exp, input string what);
    begin
      apb(idx, 2'b00, 1'b0, 4'h0, rd);
      check(rd, {28'h0, exp}, what);
    end
  endtask

  // clear flags, let the far end send, poll until reception completes
  task send(input [7:0] b, input [1:0] t, input s);
    begin
      wr(`IDX_IRQ_FLAG, 4'h7);
      tx_byte <= b;
      tail <= t;
      stop <= s;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      rd = 32'h0;
      while (rd[0] !== 1'b1) apb(`IDX_IRQ_FLAG, 2'b00, 1'b0, 4'h0, rd);
    end
  endtask

  // watchdog sized well above the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge pclk);
    errors = errors + 1;
    end_sim;
  end

  initial begin
    {presetn, psel, penable, pwrite, go, stop, clocked} = 7'h0;
    {paddr, pwdata, tx_byte, tail} = 0;
    errors = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IDX_PIN_SELECT, 4'h0, "sel");
    rdc(`IDX_XFER_CTRL, 4'h0, "ctl");
    rdc(`IDX_ERR_FLAGS, 4'h0, "err");
    rdc(`IDX_IRQ_MASK, 4'h0, "msk");
    rdc(`IDX_IRQ_FLAG, 4'h0, "flg");
    rdc(16'h0000, 4'h0, "unmapped");
    apb(`IDX_XFER_CTRL, 2'b10, 1'b0, 4'h0, rd);
    check(rd, 32'h0, "unaligned");
    $display("test reset done");
    wr(`IDX_XFER_CTRL, 4'h5);
    rdc(`IDX_XFER_CTRL, 4'h5, "ctl");
    wr(`IDX_IRQ_MASK, 4'hf);
    rdc(`IDX_IRQ_MASK, 4'h7, "msk");
    for (m = 0; m < 4; m = m + 1) begin
      wr(`IDX_PIN_SELECT, {1'b1, m[1:0], 1'b0});
      rdc(`IDX_PIN_SELECT, {1'b0, m[1:0], 1'b0}, "mode");
    end
    wr(`IDX_DATA_LO, 4'ha);
    wr(`IDX_DATA_HI, 4'h5);
    rdc(`IDX_DATA_LO, 4'ha, "dlo");
    rdc(`IDX_DATA_HI, 4'h5, "dhi");
    $display("test readback done");
    wr(`IDX_PIN_SELECT, 4'h7);
    repeat (`SETTLE_CYCLES) @(posedge pclk);
    wr(`IDX_XFER_CTRL, 4'h7);
    rdc(`IDX_XFER_CTRL, 4'h7, "busy");
    while (rd[1] !== 1'b0) apb(`IDX_XFER_CTRL, 2'b00, 1'b0, 4'h0, rd);
    check({23'h0, got_stop, got}, 32'h15a, "line");
    rdc(`IDX_IRQ_FLAG, 4'h2, "txdone");
    check({31'h0, irq}, 32'h1, "irq");
    wr(`IDX_IRQ_MASK, 4'h0);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0, "irq");
    wr(`IDX_IRQ_FLAG, 4'h0);
    rdc(`IDX_IRQ_FLAG, 4'h2, "w0");
    wr(`IDX_IRQ_FLAG, 4'h2);
    rdc(`IDX_IRQ_FLAG, 4'h0, "w1c");
    $display("test transmit done");
    wr(`IDX_XFER_CTRL, 4'hd);
    send(8'hc3, 2'b00, 1'b1);
    rdc(`IDX_DATA_LO, 4'h3, "rxlo");
    rdc(`IDX_DATA_HI, 4'hc, "rxhi");
    rdc(`IDX_ERR_FLAGS, 4'h0, "clean");
    send(8'h3c, 2'b00, 1'b1);
    rdc(`IDX_ERR_FLAGS, 4'h1, "ovr");
    rdc(`IDX_IRQ_FLAG, 4'h5, "eflg");
    wr(`IDX_ERR_FLAGS, 4'h1);
    rdc(`IDX_ERR_FLAGS, 4'h0, "ovrclr");
    wr(`IDX_XFER_CTRL, 4'hd);
    send(8'h81, 2'b00, 1'b0);
    rdc(`IDX_ERR_FLAGS, 4'h4, "frm");
    wr(`IDX_ERR_FLAGS, 4'h7);
    rdc(`IDX_ERR_FLAGS, 4'h0, "frmclr");
    wr(`IDX_PARITY, 4'h8);
    wr(`IDX_XFER_CTRL, 4'hd);
    send(8'h01, 2'b10, 1'b1);
    rdc(`IDX_ERR_FLAGS, 4'h2, "par");
    rdc(`IDX_IRQ_FLAG, 4'h5, "eflg");
    wr(`IDX_IRQ_MASK, 4'h4);
    @(posedge pclk);
    check({31'h0, irq}, 32'h1, "irq");
    wr(`IDX_ERR_FLAGS, 4'h2);
    rdc(`IDX_ERR_FLAGS, 4'h0, "parclr");
    $display("test receive done");
    // clocked master: byte out against the reply loaded into the buffer
    wr(`IDX_IRQ_FLAG, 4'h7);
    wr(`IDX_PIN_SELECT, 4'h1);
    wr(`IDX_DATA_LO, 4'h6);
    wr(`IDX_DATA_HI, 4'h9);
    tx_byte <= 8'hc5;
    clocked <= 1'b1;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wr(`IDX_XFER_CTRL, 4'hf);
    rdc(`IDX_XFER_CTRL, 4'hf, "mbusy");
    while (rd[1] !== 1'b0) apb(`IDX_XFER_CTRL, 2'b00, 1'b0, 4'h0, rd);
    check({24'h0, ck_got}, 32'h96, "mout");
    rdc(`IDX_DATA_LO, 4'h5, "mlo");
    rdc(`IDX_DATA_HI, 4'hc, "mhi");
    rdc(`IDX_IRQ_FLAG, 4'h3, "mdone");
    // clocked slave: the far end clocks once the ready pin falls
    wr(`IDX_IRQ_FLAG, 4'h3);
    wr(`IDX_PIN_SELECT, 4'h3);
    tx_byte <= 8'h3a;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wr(`IDX_XFER_CTRL, 4'hf);
    rdc(`IDX_XFER_CTRL, 4'hf, "sbusy");
    while (rd[1] !== 1'b0) apb(`IDX_XFER_CTRL, 2'b00, 1'b0, 4'h0, rd);
    check({24'h0, ck_got}, 32'hc5, "serial_data_output");
    rdc(`IDX_DATA_LO, 4'ha, "slo");
    rdc(`IDX_DATA_HI, 4'h3, "shi");
    rdc(`IDX_IRQ_FLAG, 4'h3, "sdone");
    $display("test clocked done");
    end_sim;
  end
endmodule // tb

bind serial_if_control_status serial_if_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .irq(irq), .pin_out(pin_out), .pin_oe(pin_oe), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe));
